// >>> logic/asc_pkg.sv
// Shared constants for the auxiliary storage control: pin layout, codes and sizes.
package asc_pkg;

    // Positions of each section and digit code width.
    localparam int POS_PER_SEC = 8;
    localparam int CODE_W      = 4;

    // Code that a position shows when no setup impulse arrived.
    localparam logic [3:0] BLANK_CODE = 4'hf;

    // Bit positions of the gathered pin vector that passes the synchroniser.
    localparam int P_RUN         = 0;
    localparam int P_GANG        = 1;
    localparam int P_EARLY       = 2;
    localparam int P_LATE        = 3;
    localparam int P_HOLD_CAM    = 4;
    localparam int P_PULSE_CAM   = 5;
    localparam int P_RESTORE_CAM = 6;
    localparam int P_STORAGE_CAM = 7;
    localparam int P_DIGIT_STB   = 8;
    localparam int P_FIRST_MINOR = 9;
    localparam int P_PILOT       = 10;
    localparam int P_ZONE_HUB    = 11;
    localparam int P_RO_A        = 12;
    localparam int P_RO_B        = 13;
    localparam int P_SUM_START   = 14;
    localparam int P_ZONE_TIME   = 15;
    localparam int P_SP_WIRED    = 16;
    localparam int P_AP_STORAGE  = 17;
    localparam int P_AP_UNIT     = 18;
    localparam int P_SUM_STB     = 19;
    localparam int P_CODE        = 20;
    localparam int P_NUM         = 24;
    localparam int P_ZONE        = 32;
    localparam int P_CTR_A       = 40;
    localparam int P_CTR_B       = 48;
    localparam int NPIN          = 56;

    // Punch FIFO shape.
    localparam int FIFO_DEPTH = 8;

endpackage

// >>> logic/asc_auxiliary_storage_control.sv
// Auxiliary storage sequencing control with its punch FIFO.
//
// Behaviour
// - Restore control relay picks in the first cycle after start, holds until stop.
// - Early-cycle relay is energized for the early impulse time of every cycle.
// - Gang punch switch on ties restore control to the line for hand cranking.
// - Early first-card minor impulse picks read-in pick relay; holds through cam.
// - Restore magnet fires when pick and restore control relays and restore cam agree.
// - Late first-card minor impulse picks section A read-in relay; holds through cam.
// - Read-in isolate relay pulses from its cam while a read-in relay is active.
// - Section A setup magnets store numeric digits from the third reading.
// - Section B read-in picks from pilot selector and zone hub outside early time.
// - Section B setup magnets store zone digits from the third reading.
// - Late readout hub impulse picks that section's readout relay; holds through cam.
// - Emitter relay pulses; emitter scan puts stored-value impulses on exit hubs.
// - Storage exits share punch exits with counters; panel relays pick the source.
// - Summary-length output is one continuous impulse over summary punching.
// - Alpha zone output is active only in zone time of each punch cycle.
// - Unit route brings B zones and A numerics out of the group A exits.
// - Summary storage relay picks with summary control relay, holds through storage cam.
// - Combined mode: zone time punches storage, numeric time punches counter digits.
// - Punching from storage holds zone transfer over the whole punching operation.
// - Unit route sends B zones in zone time and A numerics in numeric time.
// - Counter group B stays free while storage punches zone and numerics.
// - A restore clears and reloads; without restore or setup the value persists.
// - Each position holds a code or blank; no setup impulse leaves blank.
`timescale 1ns/1ns

module asc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = asc_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Filling side.
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Draining side.
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } asc_fifo_state_t;

    asc_fifo_state_t r;
    asc_fifo_state_t n;
    logic            do_push;
    logic            do_pop;

    assign in_ready_o  = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (r.cnt != '0);
    assign out_data_o  = r.mem[r.rp];
    assign do_push     = in_valid_i && in_ready_o;
    assign do_pop      = out_valid_o && out_ready_i;

    always_comb begin
        n = r;
        if (do_push) begin
            n.mem[r.wp] = in_data_i;
            n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
        end
        if (do_pop) begin
            n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
        end
        if (do_push && !do_pop) begin
            n.cnt = r.cnt + (AW+1)'(1);
        end else if (do_pop && !do_push) begin
            n.cnt = r.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_fifo_no_overflow: assert property (r.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
    a_fifo_full_stall: assert property (!in_ready_o && !do_pop |=> !in_ready_o)
        else $error("fifo full state lost without a pop");
endmodule

module asc_auxiliary_storage_control #(
    parameter int NPOS = asc_pkg::POS_PER_SEC
) (
    // Clock and reset.
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    // Machine timing: run, switches, impulse times and cam breakers.
    input  wire logic            machine_run_i,
    input  wire logic            gang_punch_i,
    input  wire logic            early_time_i,
    input  wire logic            late_time_i,
    input  wire logic            hold_cam_i,
    input  wire logic            pulse_cam_i,
    input  wire logic            restore_cam_i,
    input  wire logic            storage_cam_i,
    input  wire logic            digit_strobe_i,
    input  wire logic [3:0]      digit_code_i,
    // Read-in panel hubs and third-reading holes.
    input  wire logic            first_minor_i,
    input  wire logic            pilot_transferred_i,
    input  wire logic            zone_readin_hub_i,
    input  wire logic [NPOS-1:0] numeric_hole_i,
    input  wire logic [NPOS-1:0] zone_hole_i,
    // Readout hubs.
    input  wire logic            readout_hub_a_i,
    input  wire logic            readout_hub_b_i,
    // Summary punch control and panel selections.
    input  wire logic            summary_control_i,
    input  wire logic            zone_time_i,
    input  wire logic            sp_from_storage_i,
    input  wire logic            ap_to_storage_i,
    input  wire logic            ap_to_unit_i,
    input  wire logic            summary_strobe_i,
    input  wire logic [NPOS-1:0] counter_a_i,
    input  wire logic [NPOS-1:0] counter_b_i,
    // Relay states and magnet drives.
    output logic                 restore_control_relay_o,
    output logic                 early_cycle_relay_o,
    output logic                 readin_pick_relay_o,
    output logic                 restore_magnet_o,
    output logic                 section_a_readin_relay_o,
    output logic                 section_b_readin_relay_o,
    output logic                 readin_isolate_relay_o,
    output logic                 section_a_readout_relay_o,
    output logic                 section_b_readout_relay_o,
    output logic                 readout_emitter_relay_o,
    // Storage exit hubs.
    output logic [NPOS-1:0]      exit_a_o,
    output logic [NPOS-1:0]      exit_b_o,
    // Summary punch hubs and relays.
    output logic                 summary_storage_relay_o,
    output logic                 summary_length_hub_o,
    output logic                 alpha_zone_hub_o,
    output logic                 zone_transfer_relay_o,
    output logic                 unit_route_relay_o,
    // Punch magnet stream through the FIFO.
    output logic [2*NPOS-1:0]    punch_data_o,
    output logic                 punch_valid_o,
    input  wire logic            punch_ready_i,
    output logic                 punch_accept_o
);
    localparam int NP = asc_pkg::NPIN;

    typedef struct packed {
        logic [NP-1:0]                       s1;
        logic [NP-1:0]                       s2;
        logic [NP-1:0]                       s3;
        logic                                restore_ctrl;
        logic                                pick;
        logic                                rd_a;
        logic                                rd_b;
        logic                                ro_a;
        logic                                ro_b;
        logic                                sum_store;
        logic                                zone_hold;
        logic [2*NPOS-1:0][3:0]              store;
        logic [NPOS-1:0]                     exit_a;
        logic [NPOS-1:0]                     exit_b;
        logic [NPOS-1:0]                     punch_a;
        logic [NPOS-1:0]                     punch_b;
        logic                                push;
    } asc_state_t;

    asc_state_t      r;
    asc_state_t      n;
    logic [NP-1:0]   pins;
    logic            run;
    logic            early;
    logic            late;
    logic            hold_cam;
    logic            first_minor;
    logic            dstb;
    logic            sstb;
    logic [3:0]      code;
    logic            isolate;
    logic            emitter;
    logic            zt;
    logic            ur;

    // All panel and machine levels come from outside the clock domain.
    assign pins = {counter_b_i, counter_a_i, zone_hole_i, numeric_hole_i, digit_code_i,
                   summary_strobe_i, ap_to_unit_i, ap_to_storage_i, sp_from_storage_i,
                   zone_time_i, summary_control_i, readout_hub_b_i, readout_hub_a_i,
                   zone_readin_hub_i, pilot_transferred_i, first_minor_i, digit_strobe_i,
                   storage_cam_i, restore_cam_i, pulse_cam_i, hold_cam_i, late_time_i,
                   early_time_i, gang_punch_i, machine_run_i};

    assign run         = r.s2[asc_pkg::P_RUN];
    assign early       = r.s2[asc_pkg::P_EARLY];
    assign late        = r.s2[asc_pkg::P_LATE];
    assign hold_cam    = r.s2[asc_pkg::P_HOLD_CAM];
    assign first_minor = r.s2[asc_pkg::P_FIRST_MINOR];
    assign code        = r.s2[asc_pkg::P_CODE +: 4];
    assign dstb = r.s2[asc_pkg::P_DIGIT_STB] & ~r.s3[asc_pkg::P_DIGIT_STB];
    assign sstb = r.s2[asc_pkg::P_SUM_STB] & ~r.s3[asc_pkg::P_SUM_STB];

    assign early_cycle_relay_o = early;
    // Gang punch bypasses the run latch so hand cranking still restores.
    assign restore_control_relay_o = r.restore_ctrl | r.s2[asc_pkg::P_GANG];
    assign restore_magnet_o = r.pick & restore_control_relay_o
                            & r.s2[asc_pkg::P_RESTORE_CAM];
    assign isolate = (r.rd_a | r.rd_b) & r.s2[asc_pkg::P_PULSE_CAM];
    assign emitter = (r.ro_a | r.ro_b) & r.s2[asc_pkg::P_PULSE_CAM];
    assign alpha_zone_hub_o = r.sum_store & r.s2[asc_pkg::P_ZONE_TIME];
    assign summary_length_hub_o = r.sum_store;
    // Combined mode follows the alpha zone hub; storage mode is held.
    assign zt = (alpha_zone_hub_o & r.s2[asc_pkg::P_AP_STORAGE]) | r.zone_hold;
    assign ur = alpha_zone_hub_o & r.s2[asc_pkg::P_AP_UNIT];

    assign readin_pick_relay_o       = r.pick;
    assign section_a_readin_relay_o  = r.rd_a;
    assign section_b_readin_relay_o  = r.rd_b;
    assign readin_isolate_relay_o    = isolate;
    assign section_a_readout_relay_o = r.ro_a;
    assign section_b_readout_relay_o = r.ro_b;
    assign readout_emitter_relay_o   = emitter;
    assign exit_a_o                  = r.exit_a;
    assign exit_b_o                  = r.exit_b;
    assign summary_storage_relay_o   = r.sum_store;
    assign zone_transfer_relay_o     = zt;
    assign unit_route_relay_o        = ur;

    always_comb begin
        n = r;
        n.s1 = pins;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.restore_ctrl = run & (r.restore_ctrl | early);
        n.pick = (early & first_minor) | (r.pick & hold_cam);
        n.rd_a = (late & ~early & first_minor) | (r.rd_a & hold_cam);
        n.rd_b = (~early & r.s2[asc_pkg::P_PILOT] & r.s2[asc_pkg::P_ZONE_HUB])
               | (r.rd_b & hold_cam);
        // A section taking read-in cannot also pick its readout relay.
        n.ro_a = ~n.rd_a & ((late & ~early & r.s2[asc_pkg::P_RO_A])
               | (r.ro_a & hold_cam));
        n.ro_b = ~n.rd_b & ((late & ~early & r.s2[asc_pkg::P_RO_B])
               | (r.ro_b & hold_cam));
        for (int p = 0; p < 2 * NPOS; p++) begin
            if (restore_magnet_o) begin
                n.store[p] = asc_pkg::BLANK_CODE;
            end
        end
        // Setup follows the restore, so a read-in cycle ends with the new digit.
        if (dstb) begin
            for (int p = 0; p < NPOS; p++) begin
                if (r.rd_a && r.s2[asc_pkg::P_NUM + p]) begin
                    n.store[p] = code;
                end
                if (r.rd_b && r.s2[asc_pkg::P_ZONE + p]) begin
                    n.store[NPOS + p] = code;
                end
            end
        end
        for (int p = 0; p < NPOS; p++) begin
            n.exit_a[p] = dstb & emitter & r.ro_a & ~isolate
                        & (r.store[p] == code);
            n.exit_b[p] = dstb & emitter & r.ro_b & ~isolate
                        & (r.store[NPOS + p] == code);
        end
        n.sum_store = r.s2[asc_pkg::P_SUM_START]
                    | (r.sum_store & r.s2[asc_pkg::P_STORAGE_CAM]);
        n.zone_hold = r.sum_store & r.s2[asc_pkg::P_SP_WIRED];
        n.push = sstb & r.sum_store;
        for (int p = 0; p < NPOS; p++) begin
            n.punch_a[p] = 1'b0;
            n.punch_b[p] = 1'b0;
            if (sstb) begin
                if (zt) begin
                    n.punch_a[p] = ur ? (r.store[NPOS + p] == code)
                                      : (r.store[p] == code);
                end else begin
                    n.punch_a[p] = r.s2[asc_pkg::P_CTR_A + p];
                end
                n.punch_b[p] = r.s2[asc_pkg::P_CTR_B + p];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r <= '0;
            r.store <= {(2 * NPOS){asc_pkg::BLANK_CODE}};
        end else begin
            r <= n;
        end
    end

    // The punch cannot be stalled mechanically, so a full FIFO shows on punch_accept_o.
    asc_fifo #(
        .WIDTH (2 * NPOS),
        .DEPTH (asc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   ({r.punch_b, r.punch_a}),
        .in_valid_i  (r.push),
        .in_ready_o  (punch_accept_o),
        .out_data_o  (punch_data_o),
        .out_valid_o (punch_valid_o),
        .out_ready_i (punch_ready_i)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_summary_go;
        r.s2[asc_pkg::P_SUM_START] ##1 r.sum_store;
    endsequence

    a_restore_ctrl_hold: assert property (r.restore_ctrl && run |=> r.restore_ctrl)
        else $error("restore control dropped while running");
    a_early_follow: assert property ($rose(early_time_i) |-> ##2 early_cycle_relay_o)
        else $error("early relay did not follow early time");
    a_pick_source: assert property ($rose(r.pick) |-> $past(early && first_minor))
        else $error("pick relay rose without early impulse");
    a_restore_clears: assert property (restore_magnet_o && !dstb |=>
        r.store[0] == asc_pkg::BLANK_CODE)
        else $error("restore did not blank position");
    a_readin_late: assert property ($rose(r.rd_a) |-> $past(late && !early))
        else $error("section a read-in outside late time");
    a_isolate_gate: assert property (!(r.rd_a || r.rd_b) |-> !readin_isolate_relay_o)
        else $error("isolate without read-in");
    a_setup_load: assert property (dstb && r.rd_a && r.s2[asc_pkg::P_NUM] |=>
        r.store[0] == $past(code))
        else $error("numeric digit not stored");
    a_exit_isolated: assert property (readin_isolate_relay_o |=>
        exit_a_o == '0 && exit_b_o == '0)
        else $error("exit driven during read-in");
    a_no_overlap: assert property (!(r.rd_a && r.ro_a) && !(r.rd_b && r.ro_b))
        else $error("read-in and readout overlap");
    a_summary_len: assert property (s_summary_go |-> summary_length_hub_o)
        else $error("summary length hub missing");
    a_alpha_zone: assert property (alpha_zone_hub_o |->
        summary_length_hub_o && r.s2[asc_pkg::P_ZONE_TIME])
        else $error("alpha zone outside zone time");
    a_unit_route: assert property (sstb && ur && zt |=>
        r.punch_a[0] == ($past(r.store[NPOS]) == $past(code)))
        else $error("unit route did not send section b zone");
    a_group_b_free: assert property (sstb |=>
        r.punch_b == $past(r.s2[asc_pkg::P_CTR_B +: NPOS]))
        else $error("counter group b not passed");
    a_readin_b_pick: assert property ($rose(r.rd_b) |->
        $past(!early && r.s2[asc_pkg::P_PILOT] && r.s2[asc_pkg::P_ZONE_HUB]))
        else $error("section b read-in without zone hub");
    a_zone_load: assert property (dstb && r.rd_b && r.s2[asc_pkg::P_ZONE] |=>
        r.store[NPOS] == $past(code))
        else $error("zone digit not stored");
    a_readout_late: assert property ($rose(r.ro_a) |->
        $past(late && !early && r.s2[asc_pkg::P_RO_A]))
        else $error("section a readout outside late time");
    a_storage_hold: assert property (r.sum_store && r.s2[asc_pkg::P_STORAGE_CAM] |=>
        r.sum_store)
        else $error("summary storage relay dropped with cam closed");
    a_transfer_hold: assert property (r.sum_store && r.s2[asc_pkg::P_SP_WIRED] |=>
        zone_transfer_relay_o)
        else $error("zone transfer not held from storage");
    a_store_persist: assert property (!restore_magnet_o && !dstb |=>
        $stable(r.store))
        else $error("stored value changed without restore or setup");
endmodule

// >>> dv/asc_punch_model.sv
// Summary punch model that drains punch words and can stall on command.
`timescale 1ns/1ns

module asc_punch_model (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Punch word stream.
    input  wire logic [15:0] data_i,
    input  wire logic        valid_i,
    output logic             ready_o,
    // Bench control.
    input  wire logic        stall_i
);
    logic [15:0] got_q[$];

    // A word counts only on an edge where ready was already high, never on a late ready.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !stall_i;
            if (valid_i && ready_o) begin
                got_q.push_back(data_i);
            end
        end
    end
endmodule

// >>> dv/test_auxiliary_storage_control.sv
// Self-checking bench for the auxiliary storage control.
`timescale 1ns/1ns

module test_auxiliary_storage_control;
    logic clk_i = 1'b0, rst_n_i = 1'b0, machine_run_i = 1'b0, gang_punch_i = 1'b0;
    logic early_time_i = 1'b0, late_time_i = 1'b0, hold_cam_i = 1'b0, pulse_cam_i = 1'b0;
    logic restore_cam_i = 1'b0, storage_cam_i = 1'b0, digit_strobe_i = 1'b0;
    logic first_minor_i = 1'b0, pilot_transferred_i = 1'b0, zone_readin_hub_i = 1'b0;
    logic readout_hub_a_i = 1'b0, readout_hub_b_i = 1'b0, summary_control_i = 1'b0;
    logic zone_time_i = 1'b0, sp_from_storage_i = 1'b0, ap_to_storage_i = 1'b0;
    logic ap_to_unit_i = 1'b0, summary_strobe_i = 1'b0, stall = 1'b0, clr = 1'b0;
    logic [3:0]  digit_code_i = 4'h0;
    logic [7:0]  numeric_hole_i = 8'h00, zone_hole_i = 8'h00;
    logic [7:0]  counter_a_i = 8'h00, counter_b_i = 8'h00, exa_seen, exb_seen;
    logic [7:0]  exit_a_o, exit_b_o;
    logic [15:0] punch_data_o;
    logic        restore_control_relay_o, early_cycle_relay_o, readin_pick_relay_o;
    logic        restore_magnet_o, section_a_readin_relay_o, section_b_readin_relay_o;
    logic        readin_isolate_relay_o, section_a_readout_relay_o, section_b_readout_relay_o;
    logic        readout_emitter_relay_o, summary_storage_relay_o, summary_length_hub_o;
    logic        alpha_zone_hub_o, zone_transfer_relay_o, unit_route_relay_o;
    logic        punch_valid_o, punch_ready_i, punch_accept_o;
    int          n_fail = 0;
    int          checks = 0;

    always #4 clk_i = ~clk_i;

    asc_auxiliary_storage_control #(.NPOS(8)) dut_u (
        .clk_i, .rst_n_i, .machine_run_i, .gang_punch_i, .early_time_i, .late_time_i,
        .hold_cam_i, .pulse_cam_i, .restore_cam_i, .storage_cam_i, .digit_strobe_i,
        .digit_code_i, .first_minor_i, .pilot_transferred_i, .zone_readin_hub_i,
        .numeric_hole_i, .zone_hole_i, .readout_hub_a_i, .readout_hub_b_i,
        .summary_control_i, .zone_time_i, .sp_from_storage_i, .ap_to_storage_i,
        .ap_to_unit_i, .summary_strobe_i, .counter_a_i, .counter_b_i,
        .restore_control_relay_o, .early_cycle_relay_o, .readin_pick_relay_o,
        .restore_magnet_o, .section_a_readin_relay_o, .section_b_readin_relay_o,
        .readin_isolate_relay_o, .section_a_readout_relay_o, .section_b_readout_relay_o,
        .readout_emitter_relay_o, .exit_a_o, .exit_b_o, .summary_storage_relay_o,
        .summary_length_hub_o, .alpha_zone_hub_o, .zone_transfer_relay_o,
        .unit_route_relay_o, .punch_data_o, .punch_valid_o, .punch_ready_i, .punch_accept_o
    );

    asc_punch_model model_u (
        .clk_i, .rst_n_i, .data_i(punch_data_o), .valid_i(punch_valid_o),
        .ready_o(punch_ready_i), .stall_i(stall)
    );

    // Exits stand one cycle, so every edge is gathered until the bench clears them.
    always @(posedge clk_i) begin
        exa_seen <= clr ? 8'h00 : exa_seen | exit_a_o;
        exb_seen <= clr ? 8'h00 : exb_seen | exit_b_o;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One strobe pulse with a low gap after it; sum selects the summary emitter.
    task automatic strobe(input logic [3:0] code, input logic sum);
        digit_code_i = code;
        digit_strobe_i = !sum;
        summary_strobe_i = sum;
        step(2);
        digit_strobe_i = 1'b0;
        summary_strobe_i = 1'b0;
        step(4);
    endtask

    // Late readout of one section, scanning a single digit time.
    task automatic ro(input logic sec, input logic [3:0] code, input logic [7:0] exp);
        hold_cam_i = 1'b1;
        late_time_i = 1'b1;
        readout_hub_a_i = !sec;
        readout_hub_b_i = sec;
        pulse_cam_i = 1'b1;
        clr = 1'b1;
        step(4);
        clr = 1'b0;
        chk("readout relay", 1, sec ? section_b_readout_relay_o : section_a_readout_relay_o);
        chk("emitter relay", 1, readout_emitter_relay_o);
        strobe(code, 1'b0);
        chk("exit", exp, sec ? exb_seen : exa_seen);
        {hold_cam_i, late_time_i, readout_hub_a_i, readout_hub_b_i, pulse_cam_i} = 5'h00;
        step(4);
    endtask

    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(8 * 5000);
        n_fail++;
        end_sim();
    end

    initial begin
        step(10);
        rst_n_i = 1'b1;
        step(3);
        chk("accept after reset", 1, punch_accept_o);
        chk("valid after reset", 0, punch_valid_o);
        gang_punch_i = 1'b1;
        step(4);
        chk("gang restore control", 1, restore_control_relay_o);
        gang_punch_i = 1'b0;
        machine_run_i = 1'b1;
        early_time_i = 1'b1;
        step(4);
        chk("early relay on", 1, early_cycle_relay_o);
        early_time_i = 1'b0;
        step(4);
        chk("early relay off", 0, early_cycle_relay_o);
        chk("restore control held", 1, restore_control_relay_o);
        hold_cam_i = 1'b1;
        early_time_i = 1'b1;
        first_minor_i = 1'b1;
        step(4);
        chk("pick relay", 1, readin_pick_relay_o);
        chk("magnet without cam", 0, restore_magnet_o);
        restore_cam_i = 1'b1;
        step(4);
        chk("restore magnet", 1, restore_magnet_o);
        {restore_cam_i, early_time_i, late_time_i} = 3'b001;
        step(4);
        chk("section a readin", 1, section_a_readin_relay_o);
        {readout_hub_a_i, pulse_cam_i} = 2'b11;
        step(4);
        chk("isolate", 1, readin_isolate_relay_o);
        chk("readout refused", 0, section_a_readout_relay_o);
        numeric_hole_i = 8'h05;
        strobe(4'h3, 1'b0);
        {first_minor_i, late_time_i, readout_hub_a_i, pulse_cam_i, hold_cam_i} = 5'h00;
        numeric_hole_i = 8'h00;
        step(4);
        chk("section a released", 0, section_a_readin_relay_o);
        {hold_cam_i, pilot_transferred_i, zone_readin_hub_i} = 3'b111;
        step(4);
        chk("section b readin", 1, section_b_readin_relay_o);
        zone_hole_i = 8'h81;
        strobe(4'hc, 1'b0);
        {hold_cam_i, pilot_transferred_i, zone_readin_hub_i} = 3'b000;
        zone_hole_i = 8'h00;
        step(4);
        ro(1'b0, 4'h3, 8'h05);
        ro(1'b0, 4'hc, 8'h00);
        ro(1'b1, 4'hc, 8'h81);
        {summary_control_i, storage_cam_i, ap_to_storage_i, zone_time_i} = 4'hf;
        step(5);
        chk("summary storage", 1, summary_storage_relay_o);
        chk("combined zone", 1, zone_transfer_relay_o);
        zone_time_i = 1'b0;
        step(4);
        chk("combined numeric", 0, zone_transfer_relay_o);
        {ap_to_storage_i, sp_from_storage_i, ap_to_unit_i, zone_time_i} = 4'h7;
        step(5);
        chk("summary length", 1, summary_length_hub_o);
        chk("alpha zone", 1, alpha_zone_hub_o);
        chk("unit route zone", 1, unit_route_relay_o);
        counter_b_i = 8'h5a; // counter_a_i stays 0 while storage punches numerics
        strobe(4'hc, 1'b1);
        zone_time_i = 1'b0;
        stall = 1'b1;
        step(4);
        chk("alpha off", 0, alpha_zone_hub_o);
        chk("unit route numeric", 0, unit_route_relay_o);
        chk("transfer held", 1, zone_transfer_relay_o);
        for (int i = 0; i < 9; i++) begin
            counter_b_i = 8'(i);
            strobe(4'h3, 1'b1);
        end
        chk("fifo full", 0, punch_accept_o);
        stall = 1'b0;
        step(30);
        chk("words", 16'd9, 16'(model_u.got_q.size()));
        chk("zone word", 16'h5a81, model_u.got_q[0]);
        for (int i = 0; i < 8; i++) begin
            chk("numeric word", {8'(i), 8'h05}, model_u.got_q[i + 1]);
        end
        chk("drained", 0, punch_valid_o);
        end_sim();
    end
endmodule
